/* src/sbsl_top.v */
// sample buffer status, readout and byte formatting logic
//
// How it works
// - buffer off: status reads 00h
// - status: fill bit7, overrun bit6, count 5:0
// - fill flag set when count reaches watermark
// - fill flag drops once readout goes below
// - discard request empties buffer, clears fill unless watermark is 0
// - select off disables, clears fill, drops contents
// - count reports stored triplets, zero to 32
// - full plus arrival: count stays, overrun sets
// - overrun reads 0 until capacity exceeded
// - overrun clears after one triplet read out
// - discard request also clears overrun
// - select off zeroes count, clears overrun
// - big-endian: bits 11:4 low, 3:0 high nibble
// - short readout skips upper byte registers
// - fill drops from draining, no status read
`timescale 1ns/1ps
`default_nettype none
`include "sbsl_consts.vh"

module sbsl_top (
	input wire clk_in,
	input wire reset_in,
	input wire [11:0] sample_x_in,
	input wire [11:0] sample_y_in,
	input wire [11:0] sample_z_in,
	input wire sample_valid_in,
	output wire sample_ready_out,
	input wire [1:0] buffer_mode_in,
	input wire [5:0] watermark_in,
	input wire discard_req_in,
	input wire byte_order_select_in,
	input wire short_read_in,
	input wire reg_rd_in,
	input wire reg_first_in,
	input wire [7:0] reg_addr_in,
	output reg [7:0] reg_rdata_out,
	output reg reg_rvalid_out,
	output reg fill_level_flag_out,
	output reg overrun_flag_out,
	output reg [5:0] stored_triplet_count_out
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------

	// one byte of a 12-bit axis value in the selected layout
	function [7:0] fmt_byte;
		input [11:0] val;
		input second;
		input big_end;
		input short_rd;
		begin
			if (short_rd) begin
				fmt_byte = val[11:4];
			end else if (big_end) begin
				if (second) begin
					fmt_byte = {val[3:0], `SBSL_NIBBLE_ZERO};
				end else begin
					fmt_byte = val[11:4];
				end
			end else begin
				if (second) begin
					fmt_byte = {{4{val[11]}}, val[11:8]};
				end else begin
					fmt_byte = val[7:0];
				end
			end
		end
	endfunction

	// auto-increment, wrapping inside the buffer window
	function [7:0] next_addr;
		input [7:0] addr;
		input short_rd;
		begin
			if (addr == `SBSL_ADDR_BUF_Z_SECOND) begin
				next_addr = `SBSL_ADDR_BUF_X_FIRST;
			end else if (short_rd && (addr == `SBSL_ADDR_BUF_Z_FIRST)) begin
				next_addr = `SBSL_ADDR_BUF_X_FIRST;
			end else if (short_rd && ((addr == `SBSL_ADDR_BUF_X_FIRST) ||
				(addr == `SBSL_ADDR_BUF_Y_FIRST))) begin
				next_addr = addr + `SBSL_ADDR_SKIP;
			end else begin
				next_addr = addr + `SBSL_ADDR_STEP;
			end
		end
	endfunction

	// store already holds a full load of triplets
	function at_capacity;
		input [5:0] cnt;
		begin
			at_capacity = (cnt == `SBSL_CAPACITY);
		end
	endfunction

	// store holds at least one triplet
	function has_triplet;
		input [5:0] cnt;
		begin
			has_triplet = (cnt != `SBSL_CNT_ZERO);
		end
	endfunction

	// last byte of a triplet for the readout length in use
	function last_of_trip;
		input [7:0] addr;
		input short_rd;
		begin
			if (short_rd) begin
				last_of_trip = (addr == `SBSL_ADDR_BUF_Z_FIRST);
			end else begin
				last_of_trip = (addr == `SBSL_ADDR_BUF_Z_SECOND);
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	wire enabled;
	wire clear_all;
	wire stage_valid;
	wire stage_ready;
	wire [35:0] stage_data;
	wire arrive;
	wire store_wr;
	wire overrun_event;
	wire [7:0] rd_addr;
	wire last_byte;
	wire pop_trip;
	wire [35:0] head_data;
	reg [4:0] wr_ptr_r;
	reg [4:0] wr_ptr_nxt;
	reg [4:0] rd_ptr_r;
	reg [4:0] rd_ptr_nxt;
	reg [5:0] count_nxt;
	reg fill_nxt;
	reg overrun_nxt;
	reg [7:0] auto_addr_r;
	reg [11:0] latest_y_r;
	reg [11:0] latest_z_r;
	reg [7:0] status_byte;
	reg [7:0] rdata_nxt;

	// ----------------------------------------------------------------
	// staging fifo in front of the store
	// ----------------------------------------------------------------
	sbsl_fifo #(
		.WIDTH(`SBSL_TRIP_W),
		.DEPTH(`SBSL_FIFO_DEPTH),
		.AW(`SBSL_FIFO_AW)
	) u_stage (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.in_valid_in(sample_valid_in),
		.in_ready_out(sample_ready_out),
		.in_data_in({sample_x_in, sample_y_in, sample_z_in}),
		.out_valid_out(stage_valid),
		.out_ready_in(stage_ready),
		.out_data_out(stage_data)
	);

	// ----------------------------------------------------------------
	// triplet store
	// ----------------------------------------------------------------
	sbsl_mem #(
		.WIDTH(`SBSL_TRIP_W),
		.DEPTH(`SBSL_STORE_DEPTH),
		.AW(`SBSL_STORE_AW)
	) u_store (
		.clk_in(clk_in),
		.wr_en_in(store_wr),
		.wr_addr_in(wr_ptr_r),
		.wr_data_in(stage_data),
		.rd_addr_in(rd_ptr_nxt),
		.rd_data_out(head_data)
	);

	// ----------------------------------------------------------------
	// arrival and readout events
	// ----------------------------------------------------------------
	assign enabled = (buffer_mode_in != `SBSL_MODE_OFF);
	assign clear_all = !enabled || discard_req_in;
	assign rd_addr = reg_first_in ? reg_addr_in : auto_addr_r;
	assign last_byte = last_of_trip(rd_addr, short_read_in);
	assign pop_trip = reg_rd_in && last_byte && enabled &&
		has_triplet(stored_triplet_count_out);
	// arrivals stall while a triplet leaves; disabled drops them
	assign stage_ready = !pop_trip;
	assign arrive = stage_valid && stage_ready;
	assign store_wr = arrive && enabled && !discard_req_in &&
		!at_capacity(stored_triplet_count_out);
	assign overrun_event = arrive && enabled && !discard_req_in &&
		at_capacity(stored_triplet_count_out);

	// ----------------------------------------------------------------
	// pointers, count and flags
	// ----------------------------------------------------------------
	always @* begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = stored_triplet_count_out;
		if (clear_all) begin
			wr_ptr_nxt = `SBSL_PTR_ZERO;
			rd_ptr_nxt = `SBSL_PTR_ZERO;
			count_nxt = `SBSL_CNT_ZERO;
		end else begin
			if (store_wr) begin
				wr_ptr_nxt = wr_ptr_r + `SBSL_PTR_ONE;
			end
			if (pop_trip) begin
				rd_ptr_nxt = rd_ptr_r + `SBSL_PTR_ONE;
			end
			if (store_wr && !pop_trip) begin
				count_nxt = stored_triplet_count_out + `SBSL_CNT_ONE;
			end else if (pop_trip && !store_wr) begin
				count_nxt = stored_triplet_count_out - `SBSL_CNT_ONE;
			end
		end
	end

	always @* begin
		// level compare, so draining alone clears it
		fill_nxt = enabled && (count_nxt >= watermark_in);
		overrun_nxt = overrun_flag_out;
		if (overrun_event) begin
			overrun_nxt = 1'b1;
		end else if (clear_all || pop_trip) begin
			overrun_nxt = 1'b0;
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr_r <= `SBSL_PTR_ZERO;
			rd_ptr_r <= `SBSL_PTR_ZERO;
			stored_triplet_count_out <= `SBSL_CNT_ZERO;
			fill_level_flag_out <= 1'b0;
			overrun_flag_out <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			stored_triplet_count_out <= count_nxt;
			fill_level_flag_out <= fill_nxt;
			overrun_flag_out <= overrun_nxt;
		end
	end

	// ----------------------------------------------------------------
	// live output sample
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (reset_in) begin
			latest_y_r <= `SBSL_SAMPLE_RESET;
			latest_z_r <= `SBSL_SAMPLE_RESET;
		end else if (arrive) begin
			latest_y_r <= stage_data[`SBSL_Y_MSB:`SBSL_Y_LSB];
			latest_z_r <= stage_data[`SBSL_Z_MSB:`SBSL_Z_LSB];
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always @* begin
		status_byte = `SBSL_STATUS_RESET;
		if (enabled) begin
			status_byte[`SBSL_STAT_FILL_BIT] = fill_level_flag_out;
			status_byte[`SBSL_STAT_OVR_BIT] = overrun_flag_out;
			status_byte[`SBSL_STAT_CNT_MSB:`SBSL_STAT_CNT_LSB] =
				stored_triplet_count_out;
		end
		// a disabled buffer leaves the status at all zero
	end

	always @* begin
		case (rd_addr)
		`SBSL_ADDR_Y_FIRST: begin
			rdata_nxt = fmt_byte(latest_y_r, 1'b0, byte_order_select_in,
				1'b0);
		end
		`SBSL_ADDR_Y_SECOND: begin
			rdata_nxt = fmt_byte(latest_y_r, 1'b1, byte_order_select_in,
				1'b0);
		end
		`SBSL_ADDR_Z_FIRST: begin
			rdata_nxt = fmt_byte(latest_z_r, 1'b0, byte_order_select_in,
				1'b0);
		end
		`SBSL_ADDR_Z_SECOND: begin
			rdata_nxt = fmt_byte(latest_z_r, 1'b1, byte_order_select_in,
				1'b0);
		end
		`SBSL_ADDR_STATUS: begin
			rdata_nxt = status_byte;
		end
		`SBSL_ADDR_BUF_X_FIRST: begin
			rdata_nxt = fmt_byte(head_data[`SBSL_X_MSB:`SBSL_X_LSB], 1'b0,
				byte_order_select_in, short_read_in);
		end
		`SBSL_ADDR_BUF_X_SECOND: begin
			rdata_nxt = fmt_byte(head_data[`SBSL_X_MSB:`SBSL_X_LSB], 1'b1,
				byte_order_select_in, 1'b0);
		end
		`SBSL_ADDR_BUF_Y_FIRST: begin
			rdata_nxt = fmt_byte(head_data[`SBSL_Y_MSB:`SBSL_Y_LSB], 1'b0,
				byte_order_select_in, short_read_in);
		end
		`SBSL_ADDR_BUF_Y_SECOND: begin
			rdata_nxt = fmt_byte(head_data[`SBSL_Y_MSB:`SBSL_Y_LSB], 1'b1,
				byte_order_select_in, 1'b0);
		end
		`SBSL_ADDR_BUF_Z_FIRST: begin
			rdata_nxt = fmt_byte(head_data[`SBSL_Z_MSB:`SBSL_Z_LSB], 1'b0,
				byte_order_select_in, short_read_in);
		end
		`SBSL_ADDR_BUF_Z_SECOND: begin
			rdata_nxt = fmt_byte(head_data[`SBSL_Z_MSB:`SBSL_Z_LSB], 1'b1,
				byte_order_select_in, 1'b0);
		end
		default: begin
			rdata_nxt = `SBSL_BYTE_ZERO;
		end
		endcase
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= `SBSL_BYTE_ZERO;
			reg_rvalid_out <= 1'b0;
			auto_addr_r <= `SBSL_ADDR_STATUS;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_nxt;
				auto_addr_r <= next_addr(rd_addr, short_read_in);
			end
		end
	end

endmodule

`default_nettype wire

/* src/sbsl_consts.vh */
// constants of the sample buffer status logic
`ifndef SBSL_CONSTS_VH
`define SBSL_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SBSL_ADDR_Y_FIRST 8'h06
`define SBSL_ADDR_Y_SECOND 8'h07
`define SBSL_ADDR_Z_FIRST 8'h08
`define SBSL_ADDR_Z_SECOND 8'h09
`define SBSL_ADDR_STATUS 8'h0b
`define SBSL_ADDR_BUF_X_FIRST 8'h0c
`define SBSL_ADDR_BUF_X_SECOND 8'h0d
`define SBSL_ADDR_BUF_Y_FIRST 8'h0e
`define SBSL_ADDR_BUF_Y_SECOND 8'h0f
`define SBSL_ADDR_BUF_Z_FIRST 8'h10
`define SBSL_ADDR_BUF_Z_SECOND 8'h11
`define SBSL_ADDR_STEP 8'h01
`define SBSL_ADDR_SKIP 8'h02

// ----------------------------------------------------------------
// status register layout and reset
// ----------------------------------------------------------------
`define SBSL_STAT_FILL_BIT 7
`define SBSL_STAT_OVR_BIT 6
`define SBSL_STAT_CNT_MSB 5
`define SBSL_STAT_CNT_LSB 0
`define SBSL_STATUS_RESET 8'h00
`define SBSL_BYTE_ZERO 8'h00
`define SBSL_NIBBLE_ZERO 4'h0

// ----------------------------------------------------------------
// buffer operating select and capacity
// ----------------------------------------------------------------
`define SBSL_MODE_OFF 2'h0
`define SBSL_CAPACITY 6'h20
`define SBSL_CNT_ZERO 6'h00
`define SBSL_CNT_ONE 6'h01
`define SBSL_PTR_ZERO 5'h00
`define SBSL_PTR_ONE 5'h01
`define SBSL_STORE_DEPTH 32
`define SBSL_STORE_AW 5

// ----------------------------------------------------------------
// sample layout and staging fifo
// ----------------------------------------------------------------
`define SBSL_AXIS_W 12
`define SBSL_TRIP_W 36
`define SBSL_X_MSB 35
`define SBSL_X_LSB 24
`define SBSL_Y_MSB 23
`define SBSL_Y_LSB 12
`define SBSL_Z_MSB 11
`define SBSL_Z_LSB 0
`define SBSL_SAMPLE_RESET 12'h000
`define SBSL_FIFO_DEPTH 16
`define SBSL_FIFO_AW 4

`endif

/* src/sbsl_mem.v */
// triplet store with registered read data
`timescale 1ns/1ps
`default_nettype none

module sbsl_mem #(
	parameter WIDTH = 36,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_in,
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [WIDTH-1:0] wr_data_in,
	input wire [AW-1:0] rd_addr_in,
	output reg [WIDTH-1:0] rd_data_out
);

	reg [WIDTH-1:0] store_r [0:DEPTH-1];

	always @(posedge clk_in) begin
		if (wr_en_in) begin
			store_r[wr_addr_in] <= wr_data_in;
		end
		// write-first so a triplet landing at the read slot is seen at once
		if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
			rd_data_out <= wr_data_in;
		end else begin
			rd_data_out <= store_r[rd_addr_in];
		end
	end

endmodule

`default_nettype wire

/* src/sbsl_fifo.v */
// staging fifo for incoming triplets
`timescale 1ns/1ps
`default_nettype none

module sbsl_fifo #(
	parameter WIDTH = 36,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_in,
	input wire reset_in,
	input wire in_valid_in,
	output reg in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);

	localparam [AW:0] FULL_CNT = DEPTH;
	localparam [AW:0] ONE_CNT = 1;
	localparam [AW:0] ZERO_CNT = 0;
	localparam [AW-1:0] ONE_PTR = 1;
	localparam [AW-1:0] ZERO_PTR = 0;

	reg [WIDTH-1:0] slot_r [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	reg [AW:0] count_nxt;
	wire push;
	wire pop;

	assign out_valid_out = (count_r != ZERO_CNT);
	assign out_data_out = slot_r[rd_ptr_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always @* begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + ONE_CNT;
		end else if (pop && !push) begin
			count_nxt = count_r - ONE_CNT;
		end
	end

	always @(posedge clk_in) begin
		if (push) begin
			slot_r[wr_ptr_r] <= in_data_in;
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr_r <= ZERO_PTR;
			rd_ptr_r <= ZERO_PTR;
			count_r <= ZERO_CNT;
			in_ready_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + ONE_PTR;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + ONE_PTR;
			end
			count_r <= count_nxt;
			in_ready_out <= (count_nxt != FULL_CNT);
		end
	end

endmodule

`default_nettype wire

/* tb/sbsl_checker.sv */
// port assertions for the sample buffer status logic
`timescale 1ns/1ps
`default_nettype none

module sbsl_checker (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [1:0] buffer_mode_in,
	input wire logic [5:0] watermark_in,
	input wire logic discard_req_in,
	input wire logic byte_order_select_in,
	input wire logic reg_rd_in,
	input wire logic reg_first_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic fill_level_flag_out,
	input wire logic overrun_flag_out,
	input wire logic [5:0] stored_triplet_count_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	sequence s_stat_rd;
		reg_rd_in && reg_first_in && reg_addr_in == 8'h0b;
	endsequence
	a_status_off:
	assert property (s_stat_rd ##0 buffer_mode_in == 2'h0 |=>
		reg_rdata_out == 8'h00) else $error("status not zero");
	a_status_map:
	assert property (s_stat_rd ##0 buffer_mode_in != 2'h0 |=>
		reg_rdata_out == {$past(fill_level_flag_out),
		$past(overrun_flag_out), $past(stored_triplet_count_out)})
		else $error("status layout wrong");
	a_fill_level:
	assert property (!$past(reset_in) && $stable(watermark_in) &&
		$stable(buffer_mode_in) && buffer_mode_in != 2'h0 |->
		fill_level_flag_out == (stored_triplet_count_out >= watermark_in))
		else $error("fill flag wrong");
	a_ovr_rise:
	assert property ($rose(overrun_flag_out) |->
		stored_triplet_count_out == 6'h20 &&
		$past(stored_triplet_count_out) == 6'h20)
		else $error("overrun below capacity");
	a_ovr_sticky:
	assert property ($fell(overrun_flag_out) |-> $past(discard_req_in) ||
		$past(buffer_mode_in) == 2'h0 || $past(reg_rd_in) ||
		$past(reg_rvalid_out)) else $error("overrun dropped");
	a_flush_clear:
	assert property (discard_req_in && watermark_in != 6'h00 |=>
		stored_triplet_count_out == 6'h00 && !fill_level_flag_out)
		else $error("discard did not empty");
	a_off_clear:
	assert property (buffer_mode_in == 2'h0 |=> !overrun_flag_out &&
		stored_triplet_count_out == 6'h00 && !fill_level_flag_out)
		else $error("disable did not clear");
	a_count_step:
	assert property (!discard_req_in && buffer_mode_in != 2'h0 |=>
		stored_triplet_count_out <= $past(stored_triplet_count_out) + 6'h01
		&& stored_triplet_count_out + 6'h01 >=
		$past(stored_triplet_count_out)) else $error("count jumped");
	a_be_nibble:
	assert property (reg_rd_in && reg_first_in && byte_order_select_in &&
		(reg_addr_in == 8'h07 || reg_addr_in == 8'h09) |=>
		reg_rdata_out[3:0] == 4'h0) else $error("low nibble set");
endmodule

bind sbsl_top sbsl_checker u_sbsl_checker (.clk_in(clk_in),
	.reset_in(reset_in), .buffer_mode_in(buffer_mode_in),
	.watermark_in(watermark_in), .discard_req_in(discard_req_in),
	.byte_order_select_in(byte_order_select_in), .reg_rd_in(reg_rd_in),
	.reg_first_in(reg_first_in), .reg_addr_in(reg_addr_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.fill_level_flag_out(fill_level_flag_out),
	.overrun_flag_out(overrun_flag_out),
	.stored_triplet_count_out(stored_triplet_count_out));
`default_nettype wire

/* tb/sbsl_host.sv */
// host model issuing single register reads
`timescale 1ns/1ps
`default_nettype none

module sbsl_host (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output logic rd_out,
	output logic first_out,
	output logic [7:0] addr_out
);
	initial begin
		rd_out = 1'b0;
		first_out = 1'b0;
		addr_out = 8'h00;
	end
	// one strobe, answer taken after the next edge
	task automatic rd(input logic f, input logic [7:0] a,
		output logic [7:0] d, output logic ok);
		@(posedge clk_in);
		rd_out <= 1'b1;
		first_out <= f;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		ok = rvalid_in;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the sample buffer status logic
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [35:0] smp = 36'h0;
	logic smp_vld = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [5:0] wm = 6'h00;
	logic discard = 1'b0;
	logic big_end = 1'b0;
	logic short_rd = 1'b0;
	wire rd, first, rvalid, ready, fill, ovr;
	wire [7:0] addr, rdata;
	wire [5:0] cnt;
	logic [35:0] q[$];
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int i;
	sbsl_top u_sbsl_top (.clk_in(clk_in), .reset_in(reset_in),
		.sample_x_in(smp[35:24]), .sample_y_in(smp[23:12]),
		.sample_z_in(smp[11:0]), .sample_valid_in(smp_vld),
		.sample_ready_out(ready), .buffer_mode_in(mode),
		.watermark_in(wm), .discard_req_in(discard),
		.byte_order_select_in(big_end), .short_read_in(short_rd),
		.reg_rd_in(rd), .reg_first_in(first), .reg_addr_in(addr),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.fill_level_flag_out(fill), .overrun_flag_out(ovr),
		.stored_triplet_count_out(cnt));
	sbsl_host u_sbsl_host (.clk_in(clk_in), .rdata_in(rdata),
		.rvalid_in(rvalid), .rd_out(rd), .first_out(first),
		.addr_out(addr));
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_sim();
		end
	end
	function automatic logic [35:0] mk(input int n);
		mk = {n[11:0] ^ 12'h9c3, 12'h5a0 + n[11:0], ~n[11:0]};
	endfunction
	// byte k of a triplet, little or big end
	function automatic logic [7:0] bt(input logic [35:0] t, input int k,
		input logic le);
		logic [11:0] v;
		v = t[35 - 12 * (k / 2) -: 12];
		if (le) bt = (k % 2) ? {{4{v[11]}}, v[11:8]} : v[7:0];
		else bt = (k % 2) ? {v[3:0], 4'h0} : v[11:4];
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		total_checks = total_checks + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_st(input logic [7:0] e);
		repeat (4) @(posedge clk_in);
		#1;
		chk("flags and count", e, {fill, ovr, cnt});
	endtask
	task automatic rdc(input logic f, input logic [7:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		u_sbsl_host.rd(f, a, d, ok);
		chk("read valid", 8'h01, {7'h00, ok});
		chk("read data", e, d);
	endtask
	task automatic push(input int n);
		@(posedge clk_in);
		smp <= mk(n);
		smp_vld <= 1'b1;
		@(posedge clk_in);
		while (ready !== 1'b1) @(posedge clk_in);
		smp_vld <= 1'b0;
		if (mode != 2'h0 && q.size() < 32) q.push_back(mk(n));
	endtask
	// oldest triplet, full or short readout
	task automatic drain(input logic sh);
		for (int k = 0; k < 6; k = k + 1 + sh)
			rdc(k == 0, 8'h0c, bt(q[0], k, !sh));
		void'(q.pop_front());
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		rdc(1'b1, 8'h0b, 8'h00);
		@(posedge clk_in);
		mode <= 2'h1;
		wm <= 6'h03;
		push(0);
		push(1);
		chk_st(8'h02);
		push(2);
		chk_st(8'h83);
		rdc(1'b1, 8'h0b, 8'h83);
		@(posedge clk_in);
		big_end <= 1'b1;
		for (int k = 2; k < 6; k++)
			rdc(1'b1, 8'(4 + k), bt(mk(2), k, 1'b0));
		@(posedge clk_in);
		big_end <= 1'b0;
		drain(1'b0);
		chk_st(8'h02);
		for (i = 3; i < 33; i++) push(i);
		chk_st(8'ha0);
		push(33);
		push(34);
		chk_st(8'he0);
		repeat (10) @(posedge clk_in);
		chk_st(8'he0);
		@(posedge clk_in);
		short_rd <= 1'b1;
		drain(1'b1);
		chk_st(8'h9f);
		@(posedge clk_in);
		short_rd <= 1'b0;
		push(35);
		push(36);
		chk_st(8'he0);
		@(posedge clk_in);
		discard <= 1'b1;
		@(posedge clk_in);
		discard <= 1'b0;
		q.delete();
		chk_st(8'h00);
		for (i = 40; i < 73; i++) push(i);
		chk_st(8'he0);
		@(posedge clk_in);
		mode <= 2'h0;
		q.delete();
		chk_st(8'h00);
		rdc(1'b1, 8'h0b, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
